// >>> hw/cpmc_map.vh
// Register addresses, field positions, reset values and timing counts
// for the clock, power-mode and safe-load control block.
// Assumes inclusion by bare name from the design files.
`ifndef CPMC_MAP_VH
`define CPMC_MAP_VH
// Register addresses (16-bit control-port subaddress)
`define CPMC_ADDR_CORE_CTRL   16'h081c
`define CPMC_ADDR_SER_OUT     16'h081e
`define CPMC_ADDR_MP_CFG_B    16'h0821
`define CPMC_ADDR_POWER_CTRL  16'h0822
`define CPMC_ADDR_OSC_PD      16'h0826
// Core control fields (active-high: writing 1 asserts the mute or clear)
`define CPMC_CORE_CLR_BIT     2
`define CPMC_CORE_DAC_BIT     3
`define CPMC_CORE_ADC_BIT     4
// Power control fields
`define CPMC_PWR_ADC_BIT      0
`define CPMC_PWR_DAC_LSB      1
`define CPMC_PWR_REF0_BIT     6
`define CPMC_PWR_REF1_BIT     7
// Serial output control fields
`define CPMC_SO_MASTER_BIT    0
`define CPMC_SO_FREQ_LSB      1
// Pin eleven mode field in config register b
`define CPMC_PIN11_MODE_LSB   20
`define CPMC_PIN11_BCLK       4'h1
// Oscillator power-down bit
`define CPMC_OSC_PD_BIT       0
// Reset values
`define CPMC_RST_CORE         16'h0000
`define CPMC_RST_PWR          16'h0000
`define CPMC_RST_OSC          16'h0000
// PLL start-up: 2^18 reference cycles
`define CPMC_PLL_LOCK_CYCLES  262144
`define CPMC_RAMP_STEPS       64
`endif

// >>> hw/cpmc_clk_div.v
// Programmable divider producing the serial-output bit clock.
// Assumes one core clock; division by 2, 4, 8 or 16 from a 2-bit select.
`timescale 1ns/1ps
`default_nettype none
module cpmc_clk_div #(
   parameter WIDTH = 4
) (
   // Clock and reset
   input  wire       clk_in,
   input  wire       rst_n_in,
   // Control
   input  wire       enable_in,
   input  wire [1:0] sel_in,
   // Divided clock
   output reg        div_out
);
   reg [WIDTH-1:0] count;
   wire [WIDTH-1:0] half = {{(WIDTH-1){1'b0}}, 1'b1} << sel_in;

   // Toggle once every half period; held low while disabled
   always @(posedge clk_in) begin
      if (!rst_n_in || !enable_in) begin
         count   <= {WIDTH{1'b0}};
         div_out <= 1'b0;
      end else if (count == half - {{(WIDTH-1){1'b0}}, 1'b1}) begin
         count   <= {WIDTH{1'b0}};
         div_out <= ~div_out;
      end else begin
         count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end
endmodule // cpmc_clk_div
`default_nettype wire

// >>> hw/cpmc_top.v
// Clock-mode, power-reduction and safe bulk-load control of the audio core.
// Assumes the control-port decoder delivers one-cycle write strobes with a
// 16-bit subaddress and 24-bit data, synchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none
`include "cpmc_map.vh"
module cpmc_top #(
   parameter LOCK_CYCLES = `CPMC_PLL_LOCK_CYCLES,
   parameter RAMP_STEPS  = `CPMC_RAMP_STEPS
) (
   // Clock and reset
   input  wire        clk_in,
   input  wire        rst_n_in,
   // Reference clock sampled as a level
   input  wire        pll_reference_clock_in,
   // Ratio select straps
   input  wire        clock_ratio_select0_in,
   input  wire        clock_ratio_select1_in,
   // Register write/read port
   input  wire        reg_wr_in,
   input  wire        reg_rd_in,
   input  wire [15:0] reg_addr_in,
   input  wire [23:0] reg_wdata_in,
   output reg  [23:0] reg_rdata_out,
   output reg         reg_rvalid_out,
   // Status and controls
   output reg         ready_out,
   output reg  [1:0]  clock_ratio_out,
   output reg         adc_mute_out,
   output reg         dac_mute_out,
   output reg         core_clear_out,
   output reg  [5:0]  volume_out,
   output reg         adc_pd_out,
   output reg  [3:0]  dac_pd_out,
   output reg         ref_pd_out,
   output reg         osc_enable_out,
   // Multipurpose pin eleven, tri-state style pair with active-low enable
   output reg         multipurpose_pin_eleven_out,
   output reg         multipurpose_pin_eleven_oe_n_out
);
   // Start-up states, one-hot
   localparam ST_RESET = 3'b001;
   localparam ST_LOCK  = 3'b010;
   localparam ST_RUN   = 3'b100;

   reg [2:0]  state;
   reg [2:0]  rst_sync;
   reg [18:0] lock_cnt;
   reg        ref_s1;
   reg        ref_s2;
   reg        ref_s3;
   reg [15:0] core_ctrl;
   reg [15:0] serial_output_control;
   reg [23:0] multipurpose_pin_config_b;
   reg [15:0] power_ctrl;
   reg [15:0] osc_pd;
   reg [5:0]  ramp;
   wire       bclk;
   wire       sync_rst_n = rst_sync[2];
   wire       ref_rise   = ref_s2 & ~ref_s3;
   wire       bclk_en;
   wire [1:0] out_clock_frequency_select;

   // Reset resynchronised through a short chain so release is clean
   always @(posedge clk_in) begin
      if (!rst_n_in)
         rst_sync <= 3'b000;
      else
         rst_sync <= {rst_sync[1:0], 1'b1};
   end

   // Reference clock synchroniser with edge detect on the second stage
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         ref_s1 <= 1'b0;
         ref_s2 <= 1'b0;
         ref_s3 <= 1'b0;
      end else begin
         ref_s1 <= pll_reference_clock_in;
         ref_s2 <= ref_s1;
         ref_s3 <= ref_s2;
      end
   end

   // Ratio straps caught at release; later pin changes are ignored
   always @(posedge clk_in) begin
      if (!rst_n_in)
         clock_ratio_out <= 2'b00;
      else if (state == ST_RESET)
         clock_ratio_out <= {clock_ratio_select0_in,
                             clock_ratio_select1_in};
   end

   // Start-up sequencer: count reference edges until PLL lock
   always @(posedge clk_in) begin
      if (!sync_rst_n) begin
         state     <= ST_RESET;
         lock_cnt  <= 19'h00000;
         ready_out <= 1'b0;
      end else begin
         case (state)
            ST_RESET: begin
               state <= ST_LOCK;
            end
            ST_LOCK: begin
               if (ref_rise) begin
                  if (lock_cnt == LOCK_CYCLES[18:0] - 19'h00001) begin
                     state     <= ST_RUN;
                     ready_out <= 1'b1;
                  end else
                     lock_cnt <= lock_cnt + 19'h00001;
               end
            end
            ST_RUN: begin
               ready_out <= 1'b1;
            end
            default: begin
               state <= ST_RESET;
            end
         endcase
      end
   end

   // Register writes; accesses before lock are dropped
   always @(posedge clk_in) begin
      if (!sync_rst_n) begin
         core_ctrl                 <= `CPMC_RST_CORE;
         serial_output_control     <= 16'h0000;
         multipurpose_pin_config_b <= 24'h000000;
         power_ctrl                <= `CPMC_RST_PWR;
         osc_pd                    <= `CPMC_RST_OSC;
      end else if (reg_wr_in && ready_out) begin
         case (reg_addr_in)
            `CPMC_ADDR_CORE_CTRL:  core_ctrl <= reg_wdata_in[15:0];
            `CPMC_ADDR_SER_OUT:    serial_output_control <= reg_wdata_in[15:0];
            `CPMC_ADDR_MP_CFG_B:   multipurpose_pin_config_b <= reg_wdata_in;
            `CPMC_ADDR_POWER_CTRL: power_ctrl <= reg_wdata_in[15:0];
            `CPMC_ADDR_OSC_PD:     osc_pd <= reg_wdata_in[15:0];
            default: ;
         endcase
      end
   end

   // Read data, one cycle after the strobe; unmapped reads give zero
   always @(posedge clk_in) begin
      if (!sync_rst_n) begin
         reg_rdata_out  <= 24'h000000;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rvalid_out <= reg_rd_in && ready_out;
         case (reg_addr_in)
            `CPMC_ADDR_CORE_CTRL:  reg_rdata_out <= {8'h00, core_ctrl};
            `CPMC_ADDR_SER_OUT:    reg_rdata_out <= {8'h00,
                                                     serial_output_control};
            `CPMC_ADDR_MP_CFG_B:   reg_rdata_out <= multipurpose_pin_config_b;
            `CPMC_ADDR_POWER_CTRL: reg_rdata_out <= {8'h00, power_ctrl};
            `CPMC_ADDR_OSC_PD:     reg_rdata_out <= {8'h00, osc_pd};
            default:               reg_rdata_out <= 24'h000000;
         endcase
      end
   end

   // Mute, clear and power controls; volume ramps one step per cycle so
   // a DAC mute never cuts volume_out abruptly; the ADC mute is not ramped
   always @(posedge clk_in) begin
      if (!sync_rst_n) begin
         adc_mute_out   <= 1'b0;
         dac_mute_out   <= 1'b0;
         core_clear_out <= 1'b0;
         ramp           <= RAMP_STEPS[5:0] - 6'h01;
         volume_out     <= 6'h00;
         adc_pd_out     <= 1'b0;
         dac_pd_out     <= 4'h0;
         ref_pd_out     <= 1'b0;
         osc_enable_out <= 1'b1;
      end else begin
         adc_mute_out   <= core_ctrl[`CPMC_CORE_ADC_BIT];
         dac_mute_out   <= core_ctrl[`CPMC_CORE_DAC_BIT];
         core_clear_out <= core_ctrl[`CPMC_CORE_CLR_BIT];
         if (core_ctrl[`CPMC_CORE_DAC_BIT] && ramp != 6'h00)
            ramp <= ramp - 6'h01;
         else if (!core_ctrl[`CPMC_CORE_DAC_BIT] &&
                  ramp != RAMP_STEPS[5:0] - 6'h01)
            ramp <= ramp + 6'h01;
         volume_out     <= ramp;
         adc_pd_out     <= power_ctrl[`CPMC_PWR_ADC_BIT];
         dac_pd_out     <= power_ctrl[`CPMC_PWR_DAC_LSB +: 4];
         ref_pd_out     <= power_ctrl[`CPMC_PWR_REF0_BIT] &
                           power_ctrl[`CPMC_PWR_REF1_BIT];
         osc_enable_out <= ~osc_pd[`CPMC_OSC_PD_BIT];
      end
   end

   assign out_clock_frequency_select =
      serial_output_control[`CPMC_SO_FREQ_LSB +: 2];
   assign bclk_en =
      (multipurpose_pin_config_b[`CPMC_PIN11_MODE_LSB +: 4] ==
       `CPMC_PIN11_BCLK) &&
      serial_output_control[`CPMC_SO_MASTER_BIT];

   cpmc_clk_div #(
      .WIDTH (5)
   ) u_div (
      .clk_in    (clk_in),
      .rst_n_in  (sync_rst_n),
      .enable_in (bclk_en),
      .sel_in    (out_clock_frequency_select),
      .div_out   (bclk)
   );

   // Pin eleven driven only when the divided clock is selected
   always @(posedge clk_in) begin
      if (!sync_rst_n) begin
         multipurpose_pin_eleven_out      <= 1'b0;
         multipurpose_pin_eleven_oe_n_out <= 1'b1;
      end else begin
         multipurpose_pin_eleven_out      <= bclk;
         multipurpose_pin_eleven_oe_n_out <= ~bclk_en;
      end
   end
endmodule // cpmc_top
`default_nettype wire

// >>> verif/cpmc_chk_assertions.sv
// Port checker for cpmc_top, attached by bind.
// Assumes the straps stay put while the block is out of reset.
`timescale 1ns/1ps
`default_nettype none
module cpmc_chk (
   // Clock, reset and straps
   input wire logic        clk_in, rst_n_in,
   input wire logic        clock_ratio_select0_in, clock_ratio_select1_in,
   // Register port
   input wire logic        reg_wr_in, reg_rd_in, reg_rvalid_out, ready_out,
   input wire logic [15:0] reg_addr_in,
   input wire logic [23:0] reg_wdata_in,
   // Controls
   input wire logic [1:0]  clock_ratio_out,
   input wire logic        adc_mute_out, dac_mute_out, core_clear_out,
   input wire logic [5:0]  volume_out,
   input wire logic        adc_pd_out, ref_pd_out, osc_enable_out,
   input wire logic [3:0]  dac_pd_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // Accepted writes; accesses before start-up ends are dropped
   wire logic wa = reg_wr_in && ready_out;
   wire logic wp = wa && reg_addr_in == 16'h0822;
   wire logic wc = wa && reg_addr_in == 16'h081c;
   wire logic wo = wa && reg_addr_in == 16'h0826;
   property p_adc; wp |-> ##2 adc_pd_out == $past(reg_wdata_in[0], 2);
   endproperty
   a_adc: assert property (p_adc) else $error("adc power-down");
   property p_dac; wp |-> ##2 dac_pd_out == $past(reg_wdata_in[4:1], 2);
   endproperty
   a_dac: assert property (p_dac) else $error("dac power-down");
   property p_ref; wp |-> ##2 ref_pd_out ==
      ($past(reg_wdata_in[7], 2) && $past(reg_wdata_in[6], 2)); endproperty
   a_ref: assert property (p_ref) else $error("reference power-down");
   property p_core; wc |-> ##2 {adc_mute_out, dac_mute_out, core_clear_out}
      == $past(reg_wdata_in[4:2], 2); endproperty
   a_core: assert property (p_core) else $error("core control");
   property p_osc; wo |-> ##2 osc_enable_out != $past(reg_wdata_in[0], 2);
   endproperty
   a_osc: assert property (p_osc) else $error("oscillator enable");
   property p_vol; dac_mute_out && $past(dac_mute_out) &&
      $past(volume_out) != 6'h00 |-> volume_out == $past(volume_out) - 6'h01;
   endproperty
   a_vol: assert property (p_vol) else $error("volume ramp");
   property p_rv; reg_rd_in && ready_out |=> reg_rvalid_out; endproperty
   a_rv: assert property (p_rv) else $error("read answer missing");
   property p_early; !ready_out |=> !reg_rvalid_out; endproperty
   a_early: assert property (p_early) else $error("early answer");
   property p_ratio; ready_out |->
      clock_ratio_out == {clock_ratio_select0_in, clock_ratio_select1_in};
   endproperty
   a_ratio: assert property (p_ratio) else $error("clock ratio");
   property p_hold; $past(ready_out) |-> $stable(clock_ratio_out); endproperty
   a_hold: assert property (p_hold) else $error("ratio moved");
endmodule // cpmc_chk
bind cpmc_top cpmc_chk u_chk (.clk_in, .rst_n_in, .clock_ratio_select0_in,
   .clock_ratio_select1_in, .reg_wr_in, .reg_rd_in, .reg_rvalid_out,
   .ready_out, .reg_addr_in, .reg_wdata_in, .clock_ratio_out, .adc_mute_out,
   .dac_mute_out, .core_clear_out, .volume_out, .adc_pd_out, .ref_pd_out,
   .osc_enable_out, .dac_pd_out);
`default_nettype wire

// >>> verif/cpmc_ref_src.sv
// External reference clock source and strap drivers.
// Assumes the host side moves the straps only while reset is held.
`timescale 1ns/1ps
`default_nettype none
module cpmc_ref_src (
   // Strap request
   input  wire logic [1:0] ratio_in,
   // Pins toward the device
   output var  logic       ref_clk_out,
   output var  logic       sel0_out,
   output var  logic       sel1_out
);
   // Free-running from time zero so start-up can finish; phase unrelated.
   // The bench selects each of the four strap ratios in turn; the reference period is the same for all
   initial begin
      ref_clk_out = 1'b0;
      #3;
      forever #16 ref_clk_out = ~ref_clk_out;
   end
   // Straps follow the request; first digit is select0
   always_comb {sel0_out, sel1_out} = ratio_in;
endmodule // cpmc_ref_src
`default_nettype wire

// >>> verif/clock_power_mode_control_tb_top.sv
// Self-checking bench for the clock, power-mode and safe-load block.
// Assumes the reference model supplies straps and the reference clock.
`timescale 1ns/1ps
`default_nettype none
module clock_power_mode_control_tb_top;
   logic        clk_in, rst_n_in, reg_wr_in, reg_rd_in, reg_rvalid_out;
   logic        pll_reference_clock_in, ready_out, p, adc_pd_out, ref_pd_out;
   logic        clock_ratio_select0_in, clock_ratio_select1_in, osc_enable_out;
   logic        adc_mute_out, dac_mute_out, core_clear_out, mp_pin, mp_oe_n;
   logic [1:0]  ratio, clock_ratio_out;
   logic [3:0]  dac_pd_out;
   logic [5:0]  volume_out;
   logic [15:0] reg_addr_in;
   logic [23:0] reg_wdata_in, reg_rdata_out, d, v;
   // Mute and clear outputs gathered for one compare
   wire logic [23:0] cs = {21'h0, adc_mute_out, dac_mute_out, core_clear_out};
   int          num_errors, tests_run, n, e;
   cpmc_ref_src src (.ratio_in(ratio), .ref_clk_out(pll_reference_clock_in),
      .sel0_out(clock_ratio_select0_in), .sel1_out(clock_ratio_select1_in));
   cpmc_top #(.LOCK_CYCLES(16), .RAMP_STEPS(64)) dut (.clk_in, .rst_n_in,
      .pll_reference_clock_in, .clock_ratio_select0_in,
      .clock_ratio_select1_in, .reg_wr_in, .reg_rd_in, .reg_addr_in,
      .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .ready_out,
      .clock_ratio_out, .adc_mute_out, .dac_mute_out, .core_clear_out,
      .volume_out, .adc_pd_out, .dac_pd_out, .ref_pd_out, .osc_enable_out,
      .multipurpose_pin_eleven_out(mp_pin),
      .multipurpose_pin_eleven_oe_n_out(mp_oe_n));
   // 125 MHz core clock
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Write, then wait until the controls have followed
   task automatic wr(input logic [15:0] a, input logic [23:0] x);
      @(negedge clk_in);
      reg_addr_in = a;
      reg_wdata_in = x;
      reg_wr_in = 1'b1;
      repeat (3) @(negedge clk_in) reg_wr_in = 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [23:0] x);
      @(negedge clk_in);
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      // The answer stands one cycle only, so look at the next falling edge
      @(negedge clk_in) reg_rd_in = 1'b0;
      chk("rvalid", 24'h1, {23'h0, reg_rvalid_out});
      x = reg_rdata_out;
   endtask
   // Reset with new straps; a write during start-up must be dropped
   task automatic do_reset(input logic [1:0] r);
      @(negedge clk_in);
      rst_n_in = 1'b0;
      ratio = r;
      repeat (5) @(negedge clk_in);
      rst_n_in = 1'b1;
      wr(16'h0822, 24'h0000ff);
      repeat (25) @(negedge clk_in);
      chk("ready_early", 24'h0, {23'h0, ready_out});
      for (n = 0; n < 400 && ready_out !== 1'b1; n++) @(negedge clk_in);
      chk("ready", 24'h1, {23'h0, ready_out});
      chk("ratio", {22'h0, r}, {22'h0, clock_ratio_out});
      rd(16'h0822, v);
      chk("pwr_rst", 24'h0, v);
      chk("osc_rst", 24'h1, {23'h0, osc_enable_out});
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   function automatic int exp_edges(int s);
      return 64 >> (s + 1);
   endfunction
   // Watchdog far beyond the expected run of roughly a thousand cycles
   initial begin
      #200000;
      num_errors++;
      $display("[FAIL] watchdog expected done seen hang");
      tally_and_finish();
   end
   initial begin
      {rst_n_in, reg_wr_in, reg_rd_in, p} = 4'h0;
      reg_addr_in = 16'h0000;
      reg_wdata_in = 24'h000000;
      ratio = 2'b00;
      num_errors = 0;
      tests_run = 0;
      void'($urandom(32'hc901));
      for (int r = 0; r < 4; r++) do_reset(2'(r));
      // Power-down patterns: corners first, then random
      for (int k = 0; k < 24; k++) begin
         d = k == 0 ? 24'h40 : k == 1 ? 24'h80 : k == 2 ? 24'hdf
            : {8'h00, 16'($urandom)};
         wr(16'h0822, d);
         chk("adc_pd", {23'h0, d[0]}, {23'h0, adc_pd_out});
         chk("dac_pd", {20'h0, d[4:1]}, {20'h0, dac_pd_out});
         chk("ref_pd", {23'h0, d[7] & d[6]}, {23'h0, ref_pd_out});
         rd(16'h0822, v);
         chk("pwr_rd", d, v);
      end
      // Safe-load sequence: mute, zero, release
      wr(16'h081c, 24'h18);
      chk("mute", 24'h6, cs);
      repeat (70) @(negedge clk_in);
      chk("vol_dn", 24'h0, {18'h0, volume_out});
      wr(16'h081c, 24'h1c);
      chk("zero", 24'h7, cs);
      wr(16'h081c, 24'h00);
      chk("run", 24'h0, cs);
      repeat (70) @(negedge clk_in);
      chk("vol_up", 24'h3f, {18'h0, volume_out});
      wr(16'h0826, 24'h1);
      chk("osc_off", 24'h0, {23'h0, osc_enable_out});
      wr(16'h0826, 24'h0);
      chk("osc_on", 24'h1, {23'h0, osc_enable_out});
      wr(16'h0900, 24'hffffff);
      rd(16'h0900, v);
      chk("unmapped", 24'h0, v);
      // Divided clock on pin eleven for each rate
      wr(16'h0821, 24'h100000);
      for (int s = 0; s < 4; s++) begin
         wr(16'h081e, {21'h0, 2'(s), 1'b1});
         chk("mp_oe_n", 24'h0, {23'h0, mp_oe_n});
         e = 0;
         repeat (64) begin
            @(negedge clk_in);
            if (mp_pin === 1'b1 && p === 1'b0) e++;
            p = mp_pin;
         end
         chk("mp_edges", 24'(exp_edges(s)),
            (e - exp_edges(s) + 1) inside {[0:2]}
            ? 24'(exp_edges(s)) : 24'(e));
      end
      wr(16'h0821, 24'h000000);
      chk("mp_off", 24'h1, {23'h0, mp_oe_n});
      tally_and_finish();
   end
endmodule // clock_power_mode_control_tb_top
`default_nettype wire
